// ### rtl/blb_bus_ctrl.sv
// Purpose: Lock, byte lane, hold handover and burst-last control of the bus
// Assumes: clk is the double-rate input clock; bus states last two clocks
// Notes:   Address and data drive are outside; this block sequences them
`timescale 1ns/1ps
module blb_bus_ctrl #(
	parameter int BEATS = blb_pkg::BEATS_MAX
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// Core request port
	input  wire logic              req_valid,
	input  wire blb_pkg::blb_kind_t req_kind,
	input  wire logic [1:0]        req_lanes,
	input  wire logic [3:0]        req_beats,
	output logic                   req_taken,
	output logic                   beat_done,
	// Core init status
	input  wire logic              selftest_done,
	input  wire logic              selftest_pass,
	output logic                   init_done,
	output logic                   init_failed,
	// Memory side
	input  wire logic              mem_ready,
	input  wire logic [15:0]       mem_data,
	output logic                   addr_state_n,
	output logic                   addr_state_oe,
	// Lock line, open drain
	input  wire logic              lock_in,
	output logic                   lock_out,
	output logic                   lock_oe,
	// Byte lane strobes and final beat
	output logic [1:0]             byte_lane_strobe_n,
	output logic                   byte_lane_strobe_oe,
	output logic                   final_beat_n,
	output logic                   final_beat_oe,
	// Hold handover
	input  wire logic              hold_req,
	output logic                   bus_grant_ack,
	output logic                   bus_grant_ack_oe
);
	import blb_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		blb_st_t    st;
		logic       once;
		logic       atomic_pend;
		logic       intack;
		blb_kind_t  kind;
		logic [3:0] beats_left;
		logic [1:0] lanes;
		logic       ck;
		logic [1:0] ck_burst;
		logic       ck_clear;
		logic       taken;
		logic       beat;
		logic       done;
		logic       failed;
		logic       as_n;
		logic       drive;
		logic       lock_pull;
		logic [1:0] strobe_n;
		logic       final_n;
		logic       ack;
		logic       ack_en;
	} blb_ctl_t;

	localparam blb_ctl_t CTL_RESET = '{
		st: S_SELFTEST, once: 1'b0, atomic_pend: 1'b0, intack: 1'b0,
		kind: K_READ, beats_left: BEATS_ONE, lanes: LANES_NONE,
		ck: 1'b0, ck_burst: 2'h0, ck_clear: 1'b1, taken: 1'b0,
		beat: 1'b0, done: 1'b0, failed: 1'b0, as_n: 1'b1,
		drive: 1'b1, lock_pull: 1'b0, strobe_n: 2'h3,
		final_n: 1'b1, ack: 1'b0, ack_en: 1'b1};

	blb_ctl_t ctl_reg;
	blb_ctl_t ctl_next;
	logic     tick;
	logic     sum_zero;
	logic     ck_beat;

	initial begin
		if (BEATS < 1 || BEATS > BEATS_MAX)
			$error("BEATS out of range");
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Bus state enable
	blb_tick_div #(
		.DIV (BUS_CLK_DIV)
	) u_div (
		.clk    (clk),
		.resetn (resetn),
		.tick   (tick)
	);

	// Checksum of the boot image beats
	assign ck_beat = tick && ctl_reg.st == S_DATA && mem_ready &&
		ctl_reg.ck;

	blb_cksum u_cksum (
		.clk        (clk),
		.resetn     (resetn),
		.clear      (ctl_reg.ck_clear),
		.beat_valid (ck_beat),
		.beat_data  (mem_data),
		.sum_zero   (sum_zero)
	);

	// Open an address state for a new transaction
	function automatic blb_ctl_t start_xfer(input blb_ctl_t s,
			input blb_kind_t k, input logic [1:0] l,
			input logic [3:0] b);
		blb_ctl_t t;
		t = s;
		t.st = S_ADDR;
		t.kind = k;
		t.lanes = l;
		t.beats_left = (b == 4'h0) ? BEATS_ONE : b;
		t.as_n = 1'b0;
		t.drive = 1'b1;
		t.ack = 1'b0;
		if (k == K_ATOMIC_RD)
			t.lock_pull = 1'b1;
		if (k == K_ATOMIC_WR) begin
			t.lock_pull = 1'b0;
			t.atomic_pend = 1'b0;
		end
		if (k == K_INTACK) begin
			t.lock_pull = 1'b1;
			t.intack = 1'b1;
		end
		return t;
	endfunction

	// Whether a request may begin now
	function automatic logic may_start(input blb_ctl_t s,
			input blb_kind_t k, input logic lk);
		may_start = !(k == K_ATOMIC_RD && !lk && !s.lock_pull);
	endfunction

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		ctl_next = ctl_reg;
		ctl_next.taken = 1'b0;
		ctl_next.beat = 1'b0;
		ctl_next.ck_clear = 1'b0;
		if (tick) begin
			unique case (ctl_reg.st)
				S_SELFTEST: begin
					ctl_next.final_n = 1'b0;
					ctl_next.strobe_n = 2'h3;
					if (selftest_done) begin
						if (selftest_pass) begin
							ctl_next.final_n = 1'b1;
							ctl_next = start_xfer(ctl_next, K_READ,
								LANES_BOTH, CKSUM_BEATS);
							ctl_next.ck = 1'b1;
							ctl_next.ck_burst = 2'h0;
						end else begin
							ctl_next.st = S_FAILED;
							ctl_next.failed = 1'b1;
						end
					end
				end
				S_IDLE: begin
					if (hold_req && !ctl_reg.atomic_pend) begin
						ctl_next.st = S_FLOAT;
						ctl_next.drive = 1'b0;
					end else if (req_valid) begin
						if (may_start(ctl_reg, req_kind, lock_in)) begin
							ctl_next = start_xfer(ctl_next, req_kind,
								req_lanes, req_beats);
							ctl_next.taken = 1'b1;
						end else begin
							ctl_next.st = S_LOCKWAIT;
						end
					end
				end
				S_LOCKWAIT: begin
					if (lock_in)
						ctl_next.st = S_IDLE;
				end
				S_ADDR: begin
					ctl_next.st = S_DATA;
					ctl_next.as_n = 1'b1;
					ctl_next.strobe_n = ~ctl_reg.lanes;
					ctl_next.final_n = ctl_reg.beats_left != BEATS_ONE;
				end
				S_DATA: begin
					if (mem_ready) begin
						ctl_next.beat = !ctl_reg.ck;
						if (ctl_reg.beats_left == BEATS_ONE) begin
							ctl_next.strobe_n = 2'h3;
							ctl_next.final_n = 1'b1;
							if (ctl_reg.intack) begin
								ctl_next.lock_pull = 1'b0;
								ctl_next.intack = 1'b0;
							end
							if (ctl_reg.kind == K_ATOMIC_RD)
								ctl_next.atomic_pend = 1'b1;
							ctl_next.st = S_IDLE;
							if (ctl_reg.ck) begin
								if (ctl_reg.ck_burst ==
										2'(CKSUM_BURSTS - 1)) begin
									ctl_next.st = S_CK_CHECK;
								end else begin
									ctl_next = start_xfer(ctl_next,
										K_READ, LANES_BOTH, CKSUM_BEATS);
									ctl_next.ck_burst =
										ctl_reg.ck_burst + 2'h1;
								end
							end
						end else begin
							ctl_next.beats_left =
								ctl_reg.beats_left - BEATS_ONE;
							ctl_next.final_n =
								ctl_reg.beats_left != BEATS_TWO;
							ctl_next.strobe_n = ~ctl_reg.lanes;
						end
					end
				end
				S_CK_CHECK: begin
					ctl_next.ck = 1'b0;
					if (sum_zero) begin
						ctl_next.st = S_IDLE;
						ctl_next.done = 1'b1;
					end else begin
						ctl_next.st = S_FAILED;
						ctl_next.failed = 1'b1;
						ctl_next.final_n = 1'b0;
						ctl_next.strobe_n = 2'h3;
					end
				end
				S_FLOAT: begin
					ctl_next.st = S_HOLD;
					ctl_next.ack = 1'b1;
				end
				S_HOLD: begin
					if (!hold_req) begin
						ctl_next.ack = 1'b0;
						ctl_next.drive = 1'b1;
						ctl_next.st = S_IDLE;
						if (req_valid &&
								may_start(ctl_reg, req_kind, lock_in)) begin
							ctl_next = start_xfer(ctl_next, req_kind,
								req_lanes, req_beats);
							ctl_next.taken = 1'b1;
						end
					end
				end
				S_FAILED: begin
					ctl_next.final_n = 1'b0;
					ctl_next.strobe_n = 2'h3;
				end
			endcase
		end
		// Strap caught while reset is low
		if (!resetn) begin
			ctl_next = CTL_RESET;
			ctl_next.once = !lock_in;
		end
		// Emulator strap clears every enable flop
		// Done here so each enable output stays a bare flop
		if (ctl_next.once) begin
			ctl_next.drive     = 1'b0;
			ctl_next.lock_pull = 1'b0;
			ctl_next.ack_en    = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		ctl_reg <= ctl_next;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// Core side flags
	assign req_taken   = ctl_reg.taken;
	assign beat_done   = ctl_reg.beat;
	assign init_done   = ctl_reg.done;
	assign init_failed = ctl_reg.failed;

	assign lock_out = 1'b0;
	// Emulator strap already folded into the flops
	assign lock_oe = ctl_reg.lock_pull;

	assign byte_lane_strobe_n  = ctl_reg.strobe_n;
	assign byte_lane_strobe_oe = ctl_reg.drive;
	assign final_beat_n        = ctl_reg.final_n;
	assign final_beat_oe       = ctl_reg.drive;
	assign addr_state_n        = ctl_reg.as_n;
	assign addr_state_oe       = ctl_reg.drive;

	assign bus_grant_ack    = ctl_reg.ack;
	assign bus_grant_ack_oe = ctl_reg.ack_en;
endmodule

// ### include/blb_pkg.sv
// Purpose: Shared constants and types of the bus lock, hold and burst control
// Assumes: clk is the double-rate input clock, bus runs on half of it
// Notes:   All counts are in bus states unless named otherwise
package blb_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 10;
	// Bus states last two input clocks
	localparam int BUS_CLK_DIV      = 2;
	// Least reset hold, in input clocks, kept by the far side
	localparam int RESET_MIN_CLKS   = 41;

	// ------------------------------------------------------------------
	// Burst and checksum figures
	// ------------------------------------------------------------------
	localparam int           BEATS_MAX      = 8;
	localparam int           CKSUM_WORDS    = 8;
	localparam int           BEATS_PER_WORD = 2;
	localparam int           CKSUM_BURSTS   =
		CKSUM_WORDS * BEATS_PER_WORD / BEATS_MAX;
	localparam logic [3:0]   CKSUM_BEATS    = 4'h8;
	localparam logic [1:0]   LANES_NONE     = 2'h0;
	localparam logic [1:0]   LANES_BOTH     = 2'h3;
	localparam logic [3:0]   BEATS_ONE      = 4'h1;
	localparam logic [3:0]   BEATS_TWO      = 4'h2;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		K_READ,
		K_WRITE,
		K_ATOMIC_RD,
		K_ATOMIC_WR,
		K_INTACK
	} blb_kind_t;

	typedef enum logic [3:0] {
		S_SELFTEST,
		S_IDLE,
		S_LOCKWAIT,
		S_ADDR,
		S_DATA,
		S_CK_CHECK,
		S_FLOAT,
		S_HOLD,
		S_FAILED
	} blb_st_t;

endpackage

// ### rtl/blb_tick_div.sv
// Purpose: Divides the input clock into a one-cycle bus state enable
// Assumes: One clock domain, synchronous active-low reset
// Notes:   First enable comes DIV cycles after reset release
`timescale 1ns/1ps
module blb_tick_div #(
	parameter int DIV = blb_pkg::BUS_CLK_DIV
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Enable out
	output logic      tick
);
	import blb_pkg::*;

	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} blb_div_t;

	blb_div_t div_reg;
	blb_div_t div_next;

	initial begin
		if (DIV < 1 || DIV > 255)
			$error("DIV out of range");
	end

	// Count down and pulse at the wrap
	always_comb begin
		div_next = div_reg;
		div_next.tick = 1'b0;
		if (div_reg.cnt == 8'h00) begin
			div_next.cnt = 8'(DIV - 1);
			div_next.tick = 1'b1;
		end else begin
			div_next.cnt = div_reg.cnt - 8'h01;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!resetn)
			div_reg <= '{cnt: 8'(DIV - 1), tick: 1'b0};
		else
			div_reg <= div_next;
	end

	assign tick = div_reg.tick;
endmodule

// ### rtl/blb_cksum.sv
// Purpose: Sums 16-bit beats as 32-bit words, low half first
// Assumes: clear comes before the first beat of the image
// Notes:   sum_zero is valid one cycle after the last beat
`timescale 1ns/1ps
module blb_cksum (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Beat input
	input  wire logic        clear,
	input  wire logic        beat_valid,
	input  wire logic [15:0] beat_data,
	// Result
	output logic             sum_zero
);
	import blb_pkg::*;

	typedef struct packed {
		logic [31:0] acc;
		logic        high;
	} blb_ck_t;

	blb_ck_t ck_reg;
	blb_ck_t ck_next;

	// Place a beat in its half of the word
	function automatic logic [31:0] half_word(input logic [15:0] d,
			input logic hi);
		half_word = hi ? {d, 16'h0000} : {16'h0000, d};
	endfunction

	// Accumulate modulo two to the thirty-second
	always_comb begin
		ck_next = ck_reg;
		if (clear) begin
			ck_next.acc = 32'h0000_0000;
			ck_next.high = 1'b0;
		end else if (beat_valid) begin
			ck_next.acc = ck_reg.acc + half_word(beat_data, ck_reg.high);
			ck_next.high = ~ck_reg.high;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!resetn)
			ck_reg <= '0;
		else
			ck_reg <= ck_next;
	end

	assign sum_zero = (ck_reg.acc == 32'h0000_0000);
endmodule

// ### sim/blb_bus_ctrl_chk.sv
// Purpose: Port checks of the bus lock, hold and burst control
// Assumes: One clock, synchronous active-low reset
// Notes:   Bus states last two clocks
`timescale 1ns/1ps
module blb_bus_ctrl_chk (
	// Clock and reset
	input wire logic       clk,
	input wire logic       resetn,
	// Core and memory side
	input wire logic       req_taken,
	input wire logic       init_done,
	input wire logic       init_failed,
	input wire logic       mem_ready,
	input wire logic       addr_state_n,
	input wire logic       addr_state_oe,
	// Lock, lanes and hold
	input wire logic       lock_in,
	input wire logic       lock_out,
	input wire logic       lock_oe,
	input wire logic [1:0] byte_lane_strobe_n,
	input wire logic       final_beat_n,
	input wire logic       final_beat_oe,
	input wire logic       hold_req,
	input wire logic       bus_grant_ack,
	input wire logic       bus_grant_ack_oe
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_ack_reset: assert property (disable iff (1'b0)
		!resetn ##1 !resetn |=> !bus_grant_ack &&
		bus_grant_ack_oe == $past(lock_in))
		else $error("grant wrong in reset");
	a_lock_open: assert property (lock_oe |-> !lock_out)
		else $error("lock driven high");
	a_lock_free: assert property ($rose(lock_oe) |-> $past(lock_in))
		else $error("lock taken while busy");
	a_lock_addr: assert property ($rose(lock_oe) |-> !addr_state_n)
		else $error("lock outside address state");
	a_grant_float: assert property ($rose(bus_grant_ack) |->
		!$past(addr_state_oe, 2) && !addr_state_oe)
		else $error("grant before float");
	a_hold_quiet: assert property (bus_grant_ack |->
		bus_grant_ack_oe && !lock_oe && !final_beat_oe)
		else $error("hold not quiet");
	a_ack_drop: assert property (bus_grant_ack && !hold_req |->
		##[1:3] !bus_grant_ack)
		else $error("grant kept");
	a_final_wait: assert property (init_done &&
		$fell(final_beat_n) ##1 !mem_ready |=> !final_beat_n [*2])
		else $error("final beat cut short");
	a_fail_show: assert property ($past(init_failed) |->
		!final_beat_n && byte_lane_strobe_n == 2'h3)
		else $error("failure not shown");
	a_fail_late: assert property (init_done |->
		final_beat_n || byte_lane_strobe_n != 2'h3)
		else $error("failure after start");

	// Main scenarios reached
	c_lock: cover property (req_taken && lock_oe);
	c_hold: cover property ($rose(bus_grant_ack));
	c_fail: cover property ($rose(init_failed));
	c_done: cover property ($rose(init_done));
endmodule

bind blb_bus_ctrl blb_bus_ctrl_chk i_chk (
	.clk, .resetn, .req_taken, .init_done, .init_failed, .mem_ready,
	.addr_state_n, .addr_state_oe, .lock_in, .lock_out, .lock_oe,
	.byte_lane_strobe_n, .final_beat_n, .final_beat_oe, .hold_req,
	.bus_grant_ack, .bus_grant_ack_oe
);

// ### sim/blb_mem_model.sv
// Purpose: Memory side and foreign lock agent
// Assumes: Bus ticks every second clock after reset
// Notes:   Image sums to zero unless bad is set
`timescale 1ns/1ps
module blb_mem_model (
	// Clock, reset and knobs
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       slow,
	input  wire logic       bad,
	input  wire logic       ext_lock,
	// Device side
	input  wire logic [1:0] strobe_n,
	input  wire logic       lock_oe,
	output logic            lock_in,
	output logic            mem_ready,
	output logic [15:0]     mem_data,
	output logic            tick
);
	int idx;

	function automatic logic [15:0] beat(int i);
		case (i)
			0: return bad ? 16'h0002 : 16'h0001;
			2, 3: return 16'hFFFF;
			default: return 16'h0000;
		endcase
	endfunction

	assign lock_in = !(lock_oe || ext_lock);

	// Tick mirror, starts high to toggle in step with the divider
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tick <= 1'b1;
			idx <= 0;
		end else begin
			tick <= !tick;
			if (tick && mem_ready && strobe_n != 2'h3) idx <= idx + 1;
		end
	end

	// Late ready; data garbled while not ready
	initial mem_ready = 1'b0;
	always @(negedge clk) mem_ready <= !slow || $urandom % 3 == 0;
	assign mem_data = mem_ready ? beat(idx) : ~beat(idx);
endmodule

// ### sim/testbench.sv
// Purpose: Self-checking bench of the bus control
// Assumes: Bench plays core and masters
// Notes:   A beat queue predicts strobes and final marks
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
	err_count++; $display("Error at %0t: mismatch", $time); end end
module testbench;
	import blb_pkg::*;

	// ----
	// Signals and instances
	// ----
	logic        clk = 1'b0;
	logic        resetn, req_valid, req_taken, beat_done, st_done, st_pass;
	logic        init_done, init_failed, mem_ready, as_n, as_oe, lock_in;
	logic        lock_out, lock_oe, bs_oe, fb_n, fb_oe, hold_req, ack;
	logic        ack_oe, slow, bad, ext_lock, tick, lk;
	logic [1:0]  req_lanes, bs_n;
	logic [3:0]  req_beats;
	logic [15:0] mem_data;
	blb_kind_t   req_kind = K_READ;
	logic [2:0]  exp_q[$];
	int          err_count = 0, cmp_count = 0, n_done = 0;

	// Clock
	always #(CLK_PERIOD_NS / 2) clk = ~clk;

	blb_bus_ctrl i_blb_bus_ctrl (
		.clk, .resetn, .req_valid, .req_kind, .req_lanes, .req_beats,
		.req_taken, .beat_done, .selftest_done(st_done),
		.selftest_pass(st_pass), .init_done, .init_failed, .mem_ready,
		.mem_data, .addr_state_n(as_n), .addr_state_oe(as_oe), .lock_in,
		.lock_out, .lock_oe, .byte_lane_strobe_n(bs_n),
		.byte_lane_strobe_oe(bs_oe), .final_beat_n(fb_n),
		.final_beat_oe(fb_oe), .hold_req, .bus_grant_ack(ack),
		.bus_grant_ack_oe(ack_oe)
	);
	blb_mem_model i_blb_mem_model (
		.clk, .resetn, .slow, .bad, .ext_lock, .strobe_n(bs_n), .lock_oe,
		.lock_in, .mem_ready, .mem_data, .tick
	);

	// Beat model: each accepted beat pops one prediction
	always @(posedge clk) begin
		if (resetn && tick && mem_ready && bs_n != 2'h3) begin
			if (exp_q.size() == 0) begin
				`CHK(1'b0, 1'b1)
			end else begin
				`CHK(bs_n, ~exp_q[0][1:0])
				`CHK(fb_n, ~exp_q[0][2])
				void'(exp_q.pop_front());
			end
		end
		if (beat_done) n_done++;
	end

	// ----
	// Tasks
	// ----
	task automatic finish_test();
		$display("Compares %0d, errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Reset with lock level and image choice
	task automatic rst(bit emu, bit d);
		@(negedge clk);
		{resetn, st_done, st_pass, hold_req} = 4'h0;
		ext_lock = emu;
		bad = d;
		exp_q.delete();
		repeat (RESET_MIN_CLKS) @(negedge clk);
		`CHK({ack, ack_oe, fb_n, bs_n}, {1'b0, !emu, 3'h7})
		{resetn, ext_lock} = 2'h2;
	endtask

	task automatic wait_init();
		int t;
		t = 0;
		while (!init_done && !init_failed && t < 500) begin
			@(negedge clk);
			t++;
		end
	endtask

	// Self-test pass, then checksum of two eight-beat reads
	task automatic boot(bit d);
		rst(1'b0, d);
		repeat (6) @(negedge clk);
		`CHK({fb_n, bs_n}, 3'h3)
		{st_done, st_pass} = 2'h3;
		for (int i = 0; i < 16; i++) exp_q.push_back({i % 8 == 7, 2'h3});
		repeat (3) @(negedge clk);
		`CHK(fb_n, 1'b1)
		wait_init();
		`CHK({init_done, init_failed, exp_q.size() == 0}, {!d, d, 1'b1})
	endtask

	// One core request; lk is the lock drive in its address state
	task automatic do_req(blb_kind_t k, logic [1:0] l, int n, bit exp,
		output logic o_lk);
		int t;
		int d;
		t = 0;
		d = n_done;
		o_lk = 1'b0;
		@(negedge clk);
		req_valid = 1'b1;
		req_kind = k;
		req_lanes = l;
		req_beats = 4'(n);
		while (!req_taken && t < (exp ? 400 : 30)) begin
			@(negedge clk);
			t++;
		end
		`CHK(req_taken, exp)
		if (exp) begin
			o_lk = lock_oe;
			req_valid = 1'b0;
			for (int i = 1; i <= n; i++) exp_q.push_back({i == n, l});
			while (exp_q.size() != 0 && t < 800) begin
				@(negedge clk);
				t++;
			end
			repeat (2) @(negedge clk);
			`CHK(n_done - d, n)
		end
	endtask

	// ----
	// Sequence
	// ----
	initial begin
		{resetn, req_valid, st_done, st_pass, hold_req, slow, bad} = '0;
		{ext_lock, req_lanes, req_beats} = '0;
		void'($urandom(32'h6093));
		rst(1'b1, 1'b0);
		repeat (10) @(negedge clk);
		`CHK({as_oe, bs_oe, fb_oe, ack_oe, lock_oe}, 5'h00)
		rst(1'b0, 1'b0);
		{st_done, st_pass} = 2'h2;
		wait_init();
		`CHK({init_failed, fb_n, bs_n}, 4'hB)
		boot(1'b1);
		repeat (40) @(negedge clk);
		`CHK({init_failed, fb_n, bs_n}, 4'hB)
		slow = 1'b1;
		boot(1'b0);
		// Foreign lock: plain read passes, atomic start stalls
		ext_lock = 1'b1;
		do_req(K_READ, 2'h2, 3, 1'b1, lk);
		do_req(K_ATOMIC_RD, 2'h3, 2, 1'b0, lk);
		ext_lock = 1'b0;
		do_req(K_ATOMIC_RD, 2'h3, 2, 1'b1, lk);
		`CHK(lk, 1'b1)
		// Hold waits for the write half, then floats and grants
		hold_req = 1'b1;
		repeat (10) @(negedge clk);
		`CHK(ack, 1'b0)
		do_req(K_ATOMIC_WR, 2'h1, 1, 1'b1, lk);
		`CHK(lk, 1'b0)
		repeat (6) @(negedge clk);
		`CHK({ack, ack_oe, as_oe, bs_oe, fb_oe}, 5'h18)
		hold_req = 1'b0;
		do_req(K_WRITE, 2'h3, 1, 1'b1, lk);
		`CHK(ack, 1'b0)
		do_req(K_INTACK, 2'h1, 1, 1'b1, lk);
		`CHK({lk, lock_oe}, 2'h2)
		// Random bursts on slow memory, each started after the last one ends
		for (int i = 0; i < 8; i++) begin
			do_req(i[0] ? K_WRITE : K_READ, 2'(1 + $urandom % 3),
				1 + $urandom % BEATS_MAX, 1'b1, lk);
		end
		finish_test();
	end

	// Watchdog against a hung handshake
	initial begin
		#(CLK_PERIOD_NS * 20000);
		err_count++;
		finish_test();
	end
endmodule
